/* src/oled_cmd_decoder.sv */
// Display end: decodes command bytes into the panel settings
//
// Behaviour
// RULE_01: 15h sets column window start and end
// RULE_02: 75h sets row window start and end
// RULE_03: 81h sets contrast, reset 40h
// RULE_04: 84h-86h pick quarter, half, full current
// RULE_05: A0h sets remap bits, reset zero
// RULE_06: A1h loads display start line
// RULE_07: A2h sets vertical display offset
// RULE_08: A4h-A7h normal, all on, off, inverse
// RULE_09: A8h sets multiplex ratio minus one
// RULE_10: ADh supply bit applied at display on
// RULE_11: AEh display off and sleep, AFh on
// RULE_12: B0h sets precharge compensation enable
// RULE_13: B1h sets both phase lengths, nonzero
// RULE_14: B2h sets row period, reset 25h
// RULE_15: B3h sets clock divide and oscillator
// RULE_16: B4h sets precharge compensation level
// RULE_17: B8h loads fifteen gray levels
// RULE_18: BCh sets precharge voltage code
// RULE_19: BEh sets common high level code
// RULE_20: BFh sets segment low level code
// RULE_21: E3h changes nothing
// RULE_22: Status read shows display off in bit six
// RULE_23: Host sends only defined byte patterns
// RULE_24: Commit settings only after last parameter
//
// Decided for this implementation: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "oled_cmd_map.svh"
module oled_cmd_decoder (
  input  wire logic                  ref_clk_i,
  input  wire logic                  rstn_i,
  oled_link_if.device                link,
  output logic                       cfg_active_o,
  output oled_cmd_pkg::settings_t    settings_o
);
  import oled_cmd_pkg::*;

  dev_state_t s_q;
  dev_state_t s_d;
  logic [3:0] len;
  logic       len_ok;
  logic       cmd_wr;
  logic       cfg_act_q;
  logic       cfg_act_d;

  // ----------------------------------------------------------------
  // Opcode length lookup
  // ----------------------------------------------------------------
  oled_cmd_length u_len (
    .opcode_i (link.wdata),
    .count_o  (len),
    .valid_o  (len_ok)
  );

  assign cmd_wr       = link.wr_stb && !link.data_sel;
  assign settings_o   = s_q.cfg;
  assign cfg_active_o = cfg_act_q;
  assign link.rdata   = s_q.rdata;
  assign link.rvalid  = s_q.rvalid;

  // ----------------------------------------------------------------
  // Reset defaults
  // ----------------------------------------------------------------
  function automatic dev_state_t reset_state();
    dev_state_t r;
    r                      = '0;
    r.cfg.col_start        = `RST_COL_START;                 // RULE_01
    r.cfg.col_end          = `RST_COL_END;                   // RULE_01
    r.cfg.row_start        = `RST_ROW_START;                 // RULE_02
    r.cfg.row_end          = `RST_ROW_END;                   // RULE_02
    r.cfg.contrast         = `RST_CONTRAST;                  // RULE_03
    r.cfg.cur_range        = `RST_RANGE;                     // RULE_04
    r.cfg.remap            = `RST_REMAP;                     // RULE_05
    r.cfg.start_line       = `RST_LINE;                      // RULE_06
    r.cfg.offset           = `RST_OFFSET;                    // RULE_07
    r.cfg.disp_mode        = `RST_MODE;                      // RULE_08
    r.cfg.mux_ratio        = `RST_MUX;                       // RULE_09
    r.cfg.master_cfg       = `RST_MASTER;                    // RULE_10
    r.master_pend          = `RST_MASTER;                    // RULE_10
    r.cfg.disp_on          = 1'b0;                           // RULE_11
    r.cfg.pc_enable        = `RST_PC_EN;                     // RULE_12
    {r.cfg.phase_two_length, r.cfg.phase_one_length} = `RST_PHASE; // RULE_13
    r.cfg.row_period       = `RST_ROW_PERIOD;                // RULE_14
    r.cfg.clk_div          = `RST_CLK_DIV;                   // RULE_15
    r.cfg.pc_level         = `RST_PC_LEVEL;                  // RULE_16
    for (int i = 0; i < 15; i++) begin
      r.cfg.gray_table[i] = `RST_GRAY_LVL;                   // RULE_17
      r.gray_stage[i]     = `RST_GRAY_LVL;
    end
    r.cfg.pc_volt           = `RST_PC_VOLT;                  // RULE_18
    r.cfg.common_high_level = `RST_COMH_VOLT;                // RULE_19
    r.cfg.segment_low_level = `RST_SEGL_VOLT;                // RULE_20
    r.parse                 = P_OPCODE;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    int unsigned k;
    k         = 0;
    s_d       = s_q;
    cfg_act_d = cfg_act_q;
    s_d.rvalid = 1'b0;
    if (link.rd_stb && !link.data_sel) begin
      s_d.rdata                = '0;
      s_d.rdata[`STAT_OFF_BIT] = !s_q.cfg.disp_on;         // RULE_22
      s_d.rvalid               = 1'b1;
    end
    if (cmd_wr) begin
      case (s_q.parse)
        P_OPCODE: begin
          s_d.opcode = link.wdata;
          s_d.idx    = '0;
          if (!len_ok) begin
            s_d.parse = P_OPCODE;                              // RULE_23
          end else if (len != `LEN_NONE) begin
            s_d.parse  = P_PARAM;                              // RULE_24
            s_d.remain = len;
          end else if (link.wdata >= `OP_RANGE_QTR && link.wdata <= `OP_RANGE_FULL) begin
            s_d.cfg.cur_range = link.wdata[1:0];               // RULE_04
          end else if (link.wdata >= `OP_MODE_NORMAL && link.wdata <= `OP_MODE_INV) begin
            s_d.cfg.disp_mode = link.wdata[1:0];               // RULE_08
          end else if (link.wdata == `OP_DISP_OFF) begin
            s_d.cfg.disp_on = 1'b0;                            // RULE_11
          end else if (link.wdata == `OP_DISP_ON) begin
            s_d.cfg.disp_on    = 1'b1;                         // RULE_11
            s_d.cfg.master_cfg = s_q.master_pend;              // RULE_10
            cfg_act_d          = 1'b1;
          end else begin
            s_d.parse = P_OPCODE;                              // RULE_21
          end
        end
        P_PARAM: begin
          k          = 32'(s_q.idx);
          s_d.idx    = s_q.idx + 3'h1;
          s_d.remain = s_q.remain - 4'h1;                      // RULE_24
          if (s_q.idx == 3'h0) begin
            s_d.hold = link.wdata;
          end
          if (s_q.opcode == `OP_GRAY_TABLE) begin
            if (k == 0) begin
              s_d.gray_stage[0] = link.wdata[2:0];             // RULE_17
            end else begin
              s_d.gray_stage[2*k-1] = link.wdata[2:0];         // RULE_17
              s_d.gray_stage[2*k]   = link.wdata[6:4];         // RULE_17
            end
          end
          if (s_q.remain == `LEN_ONE) begin
            s_d.parse = P_OPCODE;
            if (s_q.opcode == `OP_COL_WIN) begin
              s_d.cfg.col_start = s_q.hold[5:0];               // RULE_01
              s_d.cfg.col_end   = link.wdata[5:0];             // RULE_01
            end else if (s_q.opcode == `OP_ROW_WIN) begin
              s_d.cfg.row_start = s_q.hold[6:0];               // RULE_02
              s_d.cfg.row_end   = link.wdata[6:0];             // RULE_02
            end else if (s_q.opcode == `OP_CONTRAST) begin
              s_d.cfg.contrast = link.wdata[6:0];              // RULE_03
            end else if (s_q.opcode == `OP_REMAP) begin
              s_d.cfg.remap = link.wdata[6:0];                 // RULE_05
            end else if (s_q.opcode == `OP_START_LINE) begin
              s_d.cfg.start_line = link.wdata[6:0];            // RULE_06
            end else if (s_q.opcode == `OP_OFFSET) begin
              s_d.cfg.offset = link.wdata[6:0];                // RULE_07
            end else if (s_q.opcode == `OP_MUX) begin
              s_d.cfg.mux_ratio = link.wdata[6:0];             // RULE_09
            end else if (s_q.opcode == `OP_MASTER_CFG) begin
              s_d.master_pend = link.wdata[0];                 // RULE_10
            end else if (s_q.opcode == `OP_PC_ENABLE) begin
              s_d.cfg.pc_enable = link.wdata[5:0];             // RULE_12
            end else if (s_q.opcode == `OP_PHASE) begin
              s_d.cfg.phase_one_length = link.wdata[3:0];      // RULE_13
              s_d.cfg.phase_two_length = link.wdata[7:4];      // RULE_13
            end else if (s_q.opcode == `OP_ROW_PERIOD) begin
              s_d.cfg.row_period = link.wdata;                 // RULE_14
            end else if (s_q.opcode == `OP_CLK_DIV) begin
              s_d.cfg.clk_div = link.wdata;                    // RULE_15
            end else if (s_q.opcode == `OP_PC_LEVEL) begin
              s_d.cfg.pc_level = link.wdata[2:0];              // RULE_16
            end else if (s_q.opcode == `OP_GRAY_TABLE) begin
              s_d.cfg.gray_table = s_d.gray_stage;             // RULE_17
            end else if (s_q.opcode == `OP_PC_VOLT) begin
              s_d.cfg.pc_volt = link.wdata;                    // RULE_18
            end else if (s_q.opcode == `OP_COMH_VOLT) begin
              s_d.cfg.common_high_level = link.wdata[4:0];     // RULE_19
            end else if (s_q.opcode == `OP_SEGL_VOLT) begin
              s_d.cfg.segment_low_level = link.wdata[3:0];     // RULE_20
            end
          end
        end
        default: begin
          s_d.parse = P_OPCODE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      s_q       <= reset_state();
      cfg_act_q <= 1'b0;
    end else begin
      s_q       <= s_d;
      cfg_act_q <= cfg_act_d;
    end
  end
endmodule

/* src/oled_cmd_map.svh */
// Opcodes, reset values, field positions and register offsets of the display command decoder
`ifndef OLED_CMD_MAP_SVH
`define OLED_CMD_MAP_SVH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define OP_COL_WIN     8'h15
`define OP_ROW_WIN     8'h75
`define OP_CONTRAST    8'h81
`define OP_RANGE_QTR   8'h84
`define OP_RANGE_FULL  8'h86
`define OP_REMAP       8'ha0
`define OP_START_LINE  8'ha1
`define OP_OFFSET      8'ha2
`define OP_MODE_NORMAL 8'ha4
`define OP_MODE_INV    8'ha7
`define OP_MUX         8'ha8
`define OP_MASTER_CFG  8'had
`define OP_DISP_OFF    8'hae
`define OP_DISP_ON     8'haf
`define OP_PC_ENABLE   8'hb0
`define OP_PHASE       8'hb1
`define OP_ROW_PERIOD  8'hb2
`define OP_CLK_DIV     8'hb3
`define OP_PC_LEVEL    8'hb4
`define OP_GRAY_TABLE  8'hb8
`define OP_PC_VOLT     8'hbc
`define OP_COMH_VOLT   8'hbe
`define OP_SEGL_VOLT   8'hbf
`define OP_NOP         8'he3

// ----------------------------------------------------------------
// Parameter counts
// ----------------------------------------------------------------
`define LEN_NONE       4'h0
`define LEN_ONE        4'h1
`define LEN_TWO        4'h2
`define LEN_GRAY       4'h8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_COL_START  6'h00
`define RST_COL_END    6'h3f
`define RST_ROW_START  7'h00
`define RST_ROW_END    7'h4f
`define RST_CONTRAST   7'h40
`define RST_RANGE      2'h0
`define RST_REMAP      7'h00
`define RST_LINE       7'h00
`define RST_OFFSET     7'h00
`define RST_MODE       2'h0
`define RST_MUX        7'h4f
`define RST_MASTER     1'h1
`define RST_PC_EN      6'h08
`define RST_PHASE      8'h53
`define RST_ROW_PERIOD 8'h25
`define RST_CLK_DIV    8'h41
`define RST_PC_LEVEL   3'h0
`define RST_GRAY_LVL   3'h1
`define RST_PC_VOLT    8'h80
`define RST_COMH_VOLT  5'h1d
`define RST_SEGL_VOLT  4'he

// ----------------------------------------------------------------
// Limits and status layout
// ----------------------------------------------------------------
`define ROW_PERIOD_MIN 8'h02
`define ROW_PERIOD_MAX 8'h9e
`define STAT_OFF_BIT   6
`define NIBBLE_ZERO    4'h0

// ----------------------------------------------------------------
// Controller registers on AHB-Lite
// ----------------------------------------------------------------
`define REG_CMD        32'h0000_0000
`define REG_STAT       32'h0000_0004
`define STAT_BUSY_BIT  0
`define STAT_ERR_BIT   1
`define STAT_CFG_BIT   2
`define STAT_BYTE_LSB  8
`endif

/* src/oled_cmd_pkg.sv */
// Types shared by both ends of the display command link
package oled_cmd_pkg;

  typedef enum logic [1:0] {
    P_OPCODE = 2'b01,
    P_PARAM  = 2'b10
  } parse_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'b01,
    H_WAIT = 2'b10
  } host_rd_t;

  typedef struct packed {
    logic [5:0]       col_start;
    logic [5:0]       col_end;
    logic [6:0]       row_start;
    logic [6:0]       row_end;
    logic [6:0]       contrast;
    logic [1:0]       cur_range;
    logic [6:0]       remap;
    logic [6:0]       start_line;
    logic [6:0]       offset;
    logic [1:0]       disp_mode;
    logic [6:0]       mux_ratio;
    logic             master_cfg;
    logic             disp_on;
    logic [5:0]       pc_enable;
    logic [3:0]       phase_two_length;
    logic [3:0]       phase_one_length;
    logic [7:0]       row_period;
    logic [7:0]       clk_div;
    logic [2:0]       pc_level;
    logic [14:0][2:0] gray_table;
    logic [7:0]       pc_volt;
    logic [4:0]       common_high_level;
    logic [3:0]       segment_low_level;
  } settings_t;

  typedef struct packed {
    settings_t        cfg;
    logic             master_pend;
    parse_t           parse;
    logic [7:0]       opcode;
    logic [3:0]       remain;
    logic [2:0]       idx;
    logic [7:0]       hold;
    logic [14:0][2:0] gray_stage;
    logic [7:0]       rdata;
    logic             rvalid;
  } dev_state_t;

  typedef struct packed {
    logic             a_valid;
    logic             a_write;
    logic             a_stat;
    logic [31:0]      hrdata;
    logic [3:0]       remain;
    logic [7:0]       opcode;
    logic             cfg_ok;
    logic             err;
    host_rd_t         rd_state;
    logic [7:0]       stat_byte;
    logic             wr;
    logic             rd;
    logic [7:0]       wdata;
  } host_state_t;

endpackage

/* src/oled_link_if.sv */
// Command link between the host controller and the display decoder
`timescale 1ns/1ps
interface oled_link_if;
  logic       wr_stb;
  logic       rd_stb;
  logic       data_sel;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rvalid;

  modport device (
    input  wr_stb,
    input  rd_stb,
    input  data_sel,
    input  wdata,
    output rdata,
    output rvalid
  );

  modport host (
    output wr_stb,
    output rd_stb,
    output data_sel,
    output wdata,
    input  rdata,
    input  rvalid
  );
endinterface

/* src/oled_cmd_length.sv */
// Parameter count lookup for one opcode byte
`timescale 1ns/1ps
`include "oled_cmd_map.svh"
module oled_cmd_length (
  input  wire logic [7:0] opcode_i,
  output logic      [3:0] count_o,
  output logic            valid_o
);
  always_comb begin
    valid_o = 1'b1;
    count_o = `LEN_ONE;
    if (opcode_i == `OP_COL_WIN || opcode_i == `OP_ROW_WIN) begin
      count_o = `LEN_TWO;
    end else if (opcode_i == `OP_GRAY_TABLE) begin
      count_o = `LEN_GRAY;
    end else if ((opcode_i >= `OP_RANGE_QTR && opcode_i <= `OP_RANGE_FULL)
                 || (opcode_i >= `OP_MODE_NORMAL && opcode_i <= `OP_MODE_INV)
                 || opcode_i == `OP_DISP_OFF || opcode_i == `OP_DISP_ON
                 || opcode_i == `OP_NOP) begin
      count_o = `LEN_NONE;
    end else if (opcode_i == `OP_CONTRAST || opcode_i == `OP_REMAP
                 || opcode_i == `OP_START_LINE || opcode_i == `OP_OFFSET
                 || opcode_i == `OP_MUX || opcode_i == `OP_MASTER_CFG
                 || (opcode_i >= `OP_PC_ENABLE && opcode_i <= `OP_PC_LEVEL)
                 || opcode_i == `OP_PC_VOLT || opcode_i == `OP_COMH_VOLT
                 || opcode_i == `OP_SEGL_VOLT) begin
      count_o = `LEN_ONE;
    end else begin
      valid_o = 1'b0;
    end
  end
endmodule

/* src/oled_cmd_host.sv */
// Host end: AHB-Lite registers that issue command bytes and status reads
`timescale 1ns/1ps
`include "oled_cmd_map.svh"
module oled_cmd_host (
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  oled_link_if.host        link
);
  import oled_cmd_pkg::*;

  host_state_t s_q;
  host_state_t s_d;
  logic [7:0]  byte_w;
  logic [3:0]  len;
  logic        len_ok;
  logic        refuse;
  logic [31:0] stat_word;

  oled_cmd_length u_len (
    .opcode_i (byte_w),
    .count_o  (len),
    .valid_o  (len_ok)
  );

  assign byte_w        = hwdata_i[7:0];
  assign hrdata_o      = s_q.hrdata;
  assign hreadyout_o   = 1'b1;
  assign hresp_o       = 1'b0;
  assign link.wr_stb   = s_q.wr;
  assign link.rd_stb   = s_q.rd;
  assign link.data_sel = 1'b0;
  assign link.wdata    = s_q.wdata;

  // ----------------------------------------------------------------
  // Byte screening before it goes out
  // ----------------------------------------------------------------
  always_comb begin
    refuse = 1'b0;
    if (s_q.remain == `LEN_NONE) begin
      refuse = !len_ok                                         // RULE_23
               || (byte_w == `OP_DISP_ON && !s_q.cfg_ok);      // RULE_10
    end else if (s_q.opcode == `OP_PHASE) begin
      refuse = byte_w[3:0] == `NIBBLE_ZERO
               || byte_w[7:4] == `NIBBLE_ZERO;                 // RULE_13
    end else if (s_q.opcode == `OP_ROW_PERIOD) begin
      refuse = byte_w < `ROW_PERIOD_MIN
               || byte_w > `ROW_PERIOD_MAX;                    // RULE_14
    end
    stat_word                                = '0;
    stat_word[`STAT_BUSY_BIT]                = s_q.rd_state == H_WAIT || s_q.rd;
    stat_word[`STAT_ERR_BIT]                 = s_q.err;
    stat_word[`STAT_CFG_BIT]                 = s_q.cfg_ok;
    stat_word[`STAT_BYTE_LSB +: 8]           = s_q.stat_byte;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d    = s_q;
    s_d.wr = 1'b0;
    s_d.rd = 1'b0;
    s_d.a_valid = hsel_i && htrans_i[1] && hready_i;
    if (s_d.a_valid) begin
      s_d.a_write = hwrite_i;
      s_d.a_stat  = haddr_i[3:0] == `REG_STAT;
      if (!hwrite_i) begin
        s_d.hrdata = (haddr_i[3:0] == `REG_STAT) ? stat_word : 32'h0000_0000;
      end
    end
    if (s_q.a_valid && s_q.a_write && s_q.a_stat && hwdata_i[`STAT_ERR_BIT]) begin
      s_d.err = 1'b0;
    end
    if (s_q.a_valid && s_q.a_write && !s_q.a_stat) begin
      if (refuse) begin
        s_d.err = 1'b1;
      end else begin
        s_d.wr    = 1'b1;
        s_d.wdata = byte_w;
        if (s_q.remain == `LEN_NONE) begin
          s_d.opcode = byte_w;
          s_d.remain = len;
        end else begin
          s_d.remain = s_q.remain - 4'h1;
          if (s_q.opcode == `OP_MASTER_CFG) begin
            s_d.cfg_ok = !byte_w[0];                           // RULE_10
          end
        end
      end
    end
    case (s_q.rd_state)
      H_IDLE: begin
        if (s_q.a_valid && s_q.a_write && s_q.a_stat && hwdata_i[`STAT_BUSY_BIT]) begin
          s_d.rd       = 1'b1;
          s_d.rd_state = H_WAIT;
        end
      end
      H_WAIT: begin
        if (link.rvalid) begin
          s_d.stat_byte = link.rdata;                          // RULE_22
          s_d.rd_state  = H_IDLE;
        end
      end
      default: begin
        s_d.rd_state = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      s_q          <= '0;
      s_q.rd_state <= H_IDLE;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

/* verification/oled_display_command_decoder_chk.sv */
// Checker for the command link between host and decoder
`timescale 1ns/1ps
module oled_display_command_decoder_chk (
  input  wire logic       ref_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  input  wire logic       data_sel,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_rd_answer;
    rd_stb |=> rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("no answer after status read");
  property p_rv_cause;
    rvalid |-> $past(rd_stb);
  endproperty
  a_rv_cause: assert property (p_rv_cause)
    else $error("answer without status read");
  property p_rv_pulse;
    rvalid |=> !rvalid;
  endproperty
  a_rv_pulse: assert property (p_rv_pulse)
    else $error("answer longer than one cycle");
  property p_stat_bits;
    rvalid |-> (rdata & 8'hbf) == 8'h00;
  endproperty
  a_stat_bits: assert property (p_stat_bits)
    else $error("reserved status bits set");
  property p_rd_hold;
    !rvalid |-> $stable(rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("status byte moved without a read");
  property p_rd_apart;
    rd_stb |=> !rd_stb [*2];
  endproperty
  a_rd_apart: assert property (p_rd_apart)
    else $error("status reads too close");
  property p_wr_cmd;
    wr_stb |-> !data_sel;
  endproperty
  a_wr_cmd: assert property (p_wr_cmd)
    else $error("write not in command mode");
  property p_rd_cmd;
    rd_stb |-> !data_sel;
  endproperty
  a_rd_cmd: assert property (p_rd_cmd)
    else $error("read not in command mode");
  c_write: cover property (wr_stb && wdata == 8'haf);
  c_off: cover property (rvalid && rdata[6]);
  c_on: cover property (rvalid && !rdata[6]);
endmodule

/* verification/oled_display_command_decoder_tb.sv */
// Self-checking bench for the host and the display command decoder
`timescale 1ns/1ps
`include "oled_cmd_map.svh"
module oled_display_command_decoder_tb;
  import oled_cmd_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        rstn_i    = 1'b0;
  logic        hsel      = 1'b0;
  logic [31:0] haddr     = 32'h0;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'b0;
  logic [31:0] hwdata    = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        cfg_act;
  logic [31:0] rd;
  settings_t   cfg;
  settings_t   exp;
  int          n_fail    = 0;
  int          tests_run = 0;
  logic [7:0]  strm [26] = '{8'h15, 8'h05, 8'h2a, 8'h75, 8'h03, 8'h4e, 8'h81, 8'h7f, 8'ha0,
    8'h52, 8'ha1, 8'h4f, 8'ha2, 8'h40, 8'ha8, 8'h0f, 8'hb0, 8'h28, 8'hb3, 8'h40, 8'hb4, 8'h03,
    8'hbc, 8'h1f, 8'hbe, 8'h10};
  logic [7:0]  gray [8]  = '{8'h01, 8'h11, 8'h22, 8'h32, 8'h43, 8'h54, 8'h65, 8'h76};
  oled_link_if link ();
  always #10 ref_clk_i = ~ref_clk_i;
  oled_cmd_host i_oled_cmd_host (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .link(link));
  oled_cmd_decoder i_oled_cmd_decoder (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .link(link),
    .cfg_active_o(cfg_act), .settings_o(cfg));
  oled_display_command_decoder_chk i_oled_display_command_decoder_chk (.ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i), .wr_stb(link.wr_stb), .rd_stb(link.rd_stb), .data_sel(link.data_sel),
    .wdata(link.wdata), .rdata(link.rdata), .rvalid(link.rvalid));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    tests_run++;
    if (got !== want) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic chk_cfg();
    tests_run++;
    if (cfg !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, cfg, exp);
    end
  endtask
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (hready !== 1'b1 && k < 20);
    if (hready !== 1'b1) begin
      n_fail++;
      results();
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic send(input logic [7:0] b);
    bus(1'b1, `REG_CMD, {24'h0, b});
    repeat (3) @(posedge ref_clk_i);
  endtask
  task automatic status(input logic [7:0] want);
    int k;
    bus(1'b1, `REG_STAT, 32'h1);
    k = 0;
    do begin
      bus(1'b0, `REG_STAT, 32'h0);
      k++;
    end while (rd[`STAT_BUSY_BIT] !== 1'b0 && k < 20);
    chk({23'h0, rd[15:8], rd[0]}, {23'h0, want, 1'b0});
    if (rd[0] !== 1'b0) results();
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    exp = '{col_start:`RST_COL_START, col_end:`RST_COL_END, row_start:`RST_ROW_START,
      row_end:`RST_ROW_END, contrast:`RST_CONTRAST, cur_range:`RST_RANGE, remap:`RST_REMAP,
      start_line:`RST_LINE, offset:`RST_OFFSET, disp_mode:`RST_MODE, mux_ratio:`RST_MUX,
      master_cfg:`RST_MASTER, disp_on:1'b0, pc_enable:`RST_PC_EN, phase_two_length:4'h5,
      phase_one_length:4'h3, row_period:`RST_ROW_PERIOD, clk_div:`RST_CLK_DIV,
      pc_level:`RST_PC_LEVEL, gray_table:'{default:`RST_GRAY_LVL}, pc_volt:`RST_PC_VOLT,
      common_high_level:`RST_COMH_VOLT, segment_low_level:`RST_SEGL_VOLT};
    repeat (5) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    @(posedge ref_clk_i);
    chk_cfg();
    status(8'h40);
    bus(1'b0, 32'h8, 32'h0);
    chk(rd, 32'h0);
    send(`OP_DISP_ON);
    chk_cfg();
    bus(1'b0, `REG_STAT, 32'h0);
    chk({28'h0, hresp, rd[2:0]}, 32'h2);
    bus(1'b1, `REG_STAT, 32'h2);
    $display("test reset done");
    foreach (strm[i]) send(strm[i]);
    exp.col_start = 6'h05;
    exp.col_end = 6'h2a;
    exp.row_start = 7'h03;
    exp.row_end = 7'h4e;
    exp.contrast = 7'h7f;
    exp.remap = 7'h52;
    exp.start_line = 7'h4f;
    exp.offset = 7'h40;
    exp.mux_ratio = 7'h0f;
    exp.pc_enable = 6'h28;
    exp.clk_div = 8'h40;
    exp.pc_level = 3'h3;
    exp.pc_volt = 8'h1f;
    exp.common_high_level = 5'h10;
    chk_cfg();
    for (int i = 0; i < 4; i++) begin
      send(8'ha4 + 8'(i));
      exp.disp_mode = 2'(i);
      chk_cfg();
    end
    for (int i = 0; i < 3; i++) begin
      send(8'h84 + 8'(i));
      exp.cur_range = 2'(i);
      chk_cfg();
    end
    $display("test settings done");
    send(`OP_GRAY_TABLE);
    foreach (gray[i]) begin
      if (i == 7) chk_cfg();
      send(gray[i]);
    end
    exp.gray_table[0] = gray[0][2:0];
    for (int i = 1; i < 8; i++) begin
      exp.gray_table[2*i-1] = gray[i][2:0];
      exp.gray_table[2*i] = gray[i][6:4];
    end
    chk_cfg();
    send(`OP_SEGL_VOLT);
    send(8'h02);
    exp.segment_low_level = 4'h2;
    chk_cfg();
    $display("test gray done");
    send(`OP_PHASE);
    send(8'h30);
    send(8'h47);
    send(`OP_ROW_PERIOD);
    send(8'h01);
    send(8'h9e);
    exp.phase_one_length = 4'h7;
    exp.phase_two_length = 4'h4;
    exp.row_period = 8'h9e;
    chk_cfg();
    bus(1'b0, `REG_STAT, 32'h0);
    chk({31'h0, rd[1]}, 32'h1);
    bus(1'b1, `REG_STAT, 32'h2);
    $display("test refusal done");
    send(`OP_MASTER_CFG);
    send(8'h00);
    chk_cfg();
    send(`OP_DISP_ON);
    exp.master_cfg = 1'b0;
    exp.disp_on = 1'b1;
    chk_cfg();
    chk({31'h0, cfg_act}, 32'h1);
    status(8'h00);
    send(`OP_NOP);
    chk_cfg();
    send(`OP_DISP_OFF);
    exp.disp_on = 1'b0;
    chk_cfg();
    status(8'h40);
    $display("test display done");
    results();
  end
endmodule
